// *** rtl/mesc_top.sv ***
// Purpose: Status and configuration words of a metering compute engine
// Assumes: Processor and engine share clk; processor accesses whole words
// Notes: Reads return two cycles after the strobe, marked by mpu_rvalid
`timescale 1ns/100ps
`default_nettype none
module mesc_top (
	input wire logic clk, // 10 MHz clock
	input wire logic nrst, // Async reset, active low
	input wire logic [11:0] mpu_addr, // Processor byte address
	input wire logic mpu_rd, // Read strobe, one cycle
	input wire logic mpu_wr, // Write strobe, one cycle
	input wire logic [31:0] mpu_wdata, // Write data
	output logic [31:0] mpu_rdata, // Read data
	output logic mpu_rvalid, // Read data valid pulse
	input wire logic frame_wr, // Front-end result strobe
	input wire logic [3:0] frame_idx, // Result word index
	input wire logic [31:0] frame_data, // Result value
	input wire logic sample_stb, // One per engine sample
	input wire logic [31:0] volt_a, // Phase A voltage sample, signed
	input wire logic [31:0] volt_b, // Phase B voltage sample, signed
	input wire logic [31:0] volt_c, // Phase C voltage sample, signed
	input wire logic pass_end, // End-of-pass pulse
	input wire logic [31:0] real_energy_sum, // Engine real energy
	input wire logic [31:0] reactive_energy_sum, // Engine reactive energy
	input wire logic [31:0] engine_gain_trim, // Engine computed trim
	output logic [31:0] real_pulse_rate, // Selected real pulse rate
	output logic [31:0] reactive_pulse_rate, // Selected reactive pulse rate
	output logic [31:0] reference_gain_trim, // Trim in use
	output logic [2:0] current_gain8, // Gain-eight select per phase
	output logic [1:0] pll_phase, // Phase steering lock loop
	output logic [1:0] pulse_scale, // Slow and fast scaling
	output logic aux_pulse_output // Sag signalling output
);
	logic [31:0] engine_config_word_r;
	logic [31:0] engine_status_word_r;
	logic [31:0] sag_threshold_r;
	logic [31:0] mpu_real_rate_r;
	logic [31:0] mpu_react_rate_r;
	logic [31:0] trim_r;
	logic [31:0] volt [0:2];
	logic [2:0] sag_flag_r;
	logic [2:0] sag_flag_nxt;
	logic [2:0] sag_seen_r;
	logic fundamental_square_wave_r;
	logic [9:0] word_adr;
	logic rd_raw_r;
	logic rd_pend_r;
	logic [31:0] rd_hold_r;
	logic [31:0] raw_q;
	logic [7:0] sag_sample_count;
	logic [1:0] phase_sel;
	logic [31:0] sel_volt;

	// Byte address to engine word; lane bits ignored for word access
	assign word_adr = mpu_addr[11:2];
	assign sag_sample_count = engine_config_word_r[mesc_pkg::CFG_CNT_HI:mesc_pkg::CFG_CNT_LO];
	assign phase_sel = {engine_config_word_r[mesc_pkg::CFG_PHSEL1],
		engine_config_word_r[mesc_pkg::CFG_PHSEL0]};
	assign volt[0] = volt_a;
	assign volt[1] = volt_b;
	assign volt[2] = volt_c;

	// ------------------------------------------------------------
	// Raw front-end words
	// ------------------------------------------------------------
	// Mapping of channel to word is set by frame_idx wiring only
	mesc_raw_mem u_raw (
		.clk(clk),
		.nrst(nrst),
		.wr_en(frame_wr),
		.wr_idx(frame_idx),
		.wr_data(frame_data),
		.rd_idx(word_adr[3:0]),
		.rd_data(raw_q)
	);

	// ------------------------------------------------------------
	// Processor writes
	// ------------------------------------------------------------
	// Config word, writable any time
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			engine_config_word_r <= mesc_pkg::CONFIG_RST;
		end else if (mpu_wr && word_adr == mesc_pkg::ADR_CONFIG) begin
			engine_config_word_r <= mpu_wdata;
		end
	end

	// Threshold and processor pulse-rate words
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sag_threshold_r <= mesc_pkg::WORD_RST;
			mpu_real_rate_r <= mesc_pkg::WORD_RST;
			mpu_react_rate_r <= mesc_pkg::WORD_RST;
		end else if (mpu_wr) begin
			if (word_adr == mesc_pkg::ADR_SAG_THRESHOLD) begin
				sag_threshold_r <= mpu_wdata;
			end else if (word_adr == mesc_pkg::ADR_MPU_REAL) begin
				mpu_real_rate_r <= mpu_wdata;
			end else if (word_adr == mesc_pkg::ADR_MPU_REACT) begin
				mpu_react_rate_r <= mpu_wdata;
			end
		end
	end

	// Gain trim: engine owns it unless the owner bit hands it over
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			trim_r <= mesc_pkg::WORD_RST;
		end else if (!engine_config_word_r[mesc_pkg::CFG_TEMP_OWNER]) begin
			if (pass_end) begin
				trim_r <= engine_gain_trim;
			end
		end else if (mpu_wr && word_adr == mesc_pkg::ADR_GAIN_TRIM) begin
			trim_r <= mpu_wdata;
		end
	end

	// ------------------------------------------------------------
	// Sag detection, per phase
	// ------------------------------------------------------------
	// Equal to threshold counts as neither below nor above: flag holds
	for (genvar p = 0; p < 3; p++) begin : g_sag
		logic [31:0] mag;
		logic [7:0] cnt_r;
		logic below;
		logic above;
		assign mag = volt[p][31] ? (32'h0000_0000 - volt[p]) : volt[p];
		assign below = mag < sag_threshold_r;
		assign above = mag > sag_threshold_r;

		// Run length of consecutive low samples, saturating at the count
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				cnt_r <= 8'h00;
			end else if (!engine_config_word_r[mesc_pkg::CFG_SAGEN_A + p]) begin
				cnt_r <= 8'h00;
			end else if (sample_stb) begin
				if (!below) begin
					cnt_r <= 8'h00;
				end else if (cnt_r != sag_sample_count) begin
					cnt_r <= cnt_r + 8'h01;
				end
			end
		end

		// Flag sets on reaching count, clears once above threshold or when the phase is disabled
		always_comb begin
			sag_flag_nxt[p] = sag_flag_r[p];
			if (!engine_config_word_r[mesc_pkg::CFG_SAGEN_A + p]) begin
				sag_flag_nxt[p] = 1'b0;
			end else if (sample_stb && above) begin
				sag_flag_nxt[p] = 1'b0;
			end else if (sample_stb && below && (cnt_r + 8'h01 >= sag_sample_count)) begin
				sag_flag_nxt[p] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sag_flag_r <= 3'h0;
		end else begin
			sag_flag_r <= sag_flag_nxt;
		end
	end

	// ------------------------------------------------------------
	// Fundamental square wave from selected phase
	// ------------------------------------------------------------
	// Sign of the chosen voltage; code 3 falls back to phase A
	assign sel_volt = (phase_sel == 2'h1) ? volt_b :
		(phase_sel == 2'h2) ? volt_c : volt_a;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fundamental_square_wave_r <= 1'b0;
		end else if (sample_stb) begin
			fundamental_square_wave_r <= !sel_volt[31];
		end
	end

	// ------------------------------------------------------------
	// Status word, one snapshot per pass
	// ------------------------------------------------------------
	// Whole word loaded at once so a read never mixes two passes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			engine_status_word_r <= mesc_pkg::WORD_RST;
		end else if (pass_end) begin
			engine_status_word_r <= mesc_pkg::WORD_RST;
			engine_status_word_r[mesc_pkg::ST_SQUARE_WAVE] <= fundamental_square_wave_r;
			// Present flags only, nothing ored from older snapshots
			engine_status_word_r[mesc_pkg::ST_SAG_A +: 3] <= sag_flag_r;
		end
	end

	// ------------------------------------------------------------
	// Aux pulse output
	// ------------------------------------------------------------
	// Toggle once per cycle in which any phase newly detects a sag; a toggle lets either edge interrupt
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sag_seen_r <= 3'h0;
			aux_pulse_output <= 1'b0;
		end else begin
			sag_seen_r <= sag_flag_r;
			if (engine_config_word_r[mesc_pkg::CFG_SAG_PULSE] &&
				|(sag_flag_r & ~sag_seen_r)) begin
				aux_pulse_output <= !aux_pulse_output;
			end
		end
	end

	// ------------------------------------------------------------
	// Control outputs to the engine datapath
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			current_gain8 <= 3'h0;
			pll_phase <= 2'h0;
			pulse_scale <= 2'h0;
			real_pulse_rate <= mesc_pkg::WORD_RST;
			reactive_pulse_rate <= mesc_pkg::WORD_RST;
			reference_gain_trim <= mesc_pkg::WORD_RST;
		end else begin
			current_gain8 <= engine_config_word_r[mesc_pkg::CFG_GAIN8_C:
				mesc_pkg::CFG_GAIN8_A];
			pll_phase <= phase_sel;
			pulse_scale <= {engine_config_word_r[mesc_pkg::CFG_PULSE_FAST],
				engine_config_word_r[mesc_pkg::CFG_PULSE_SLOW]};
			if (engine_config_word_r[mesc_pkg::CFG_PULSE_SRC]) begin
				real_pulse_rate <= mpu_real_rate_r;
				reactive_pulse_rate <= mpu_react_rate_r;
			end else begin
				real_pulse_rate <= real_energy_sum;
				reactive_pulse_rate <= reactive_energy_sum;
			end
			reference_gain_trim <= trim_r;
		end
	end

	// ------------------------------------------------------------
	// Processor reads
	// ------------------------------------------------------------
	// First stage: decode and hold non-raw words; raw memory reads meanwhile
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_pend_r <= 1'b0;
			rd_raw_r <= 1'b0;
			rd_hold_r <= mesc_pkg::WORD_RST;
		end else begin
			rd_pend_r <= mpu_rd;
			rd_raw_r <= 1'b0;
			rd_hold_r <= mesc_pkg::WORD_RST;
			if (mpu_rd) begin
				if (word_adr <= mesc_pkg::ADR_NEUTRAL_CUR || word_adr == mesc_pkg::ADR_DIE_TEMP ||
					word_adr == mesc_pkg::ADR_BATTERY) begin
					rd_raw_r <= 1'b1;
				end else if (word_adr == mesc_pkg::ADR_PART) begin
					rd_hold_r <= {16'h0000, mesc_pkg::PART_CODE, mesc_pkg::REVISION};
				end else if (word_adr == mesc_pkg::ADR_CONFIG) begin
					rd_hold_r <= engine_config_word_r;
				end else if (word_adr == mesc_pkg::ADR_SAG_THRESHOLD) begin
					rd_hold_r <= sag_threshold_r;
				end else if (word_adr == mesc_pkg::ADR_MPU_REAL) begin
					rd_hold_r <= mpu_real_rate_r;
				end else if (word_adr == mesc_pkg::ADR_MPU_REACT) begin
					rd_hold_r <= mpu_react_rate_r;
				end else if (word_adr == mesc_pkg::ADR_GAIN_TRIM) begin
					rd_hold_r <= trim_r;
				end else if (word_adr == mesc_pkg::ADR_STATUS) begin
					rd_hold_r <= engine_status_word_r;
				end
			end
		end
	end

	// Second stage: registered answer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mpu_rdata <= mesc_pkg::WORD_RST;
			mpu_rvalid <= 1'b0;
		end else begin
			mpu_rvalid <= rd_pend_r;
			if (rd_pend_r) begin
				mpu_rdata <= rd_raw_r ? raw_q : rd_hold_r;
			end
		end
	end
endmodule
`default_nettype wire

// *** rtl/mesc_pkg.sv ***
// Purpose: Shared constants for the metering engine status/config block
// Assumes: Word addresses are engine word addresses; processor byte address = 4x
// Notes: Config field layout and extra word addresses are fixed here
`default_nettype none
package mesc_pkg;
	// ------------------------------------------------------------
	// Engine word addresses
	// ------------------------------------------------------------
	localparam logic [9:0] ADR_RAW_FIRST = 10'h000; // First raw word
	localparam logic [9:0] ADR_RAW_LAST = 10'h00B; // Last raw word
	localparam logic [9:0] ADR_PHA_CUR = 10'h000;
	localparam logic [9:0] ADR_PHA_VOLT = 10'h001;
	localparam logic [9:0] ADR_PHB_CUR = 10'h002;
	localparam logic [9:0] ADR_PHB_VOLT = 10'h003;
	localparam logic [9:0] ADR_PHC_CUR = 10'h004;
	localparam logic [9:0] ADR_PHC_VOLT = 10'h005;
	localparam logic [9:0] ADR_NEUTRAL_CUR = 10'h006;
	localparam logic [9:0] ADR_DIE_TEMP = 10'h00A;
	localparam logic [9:0] ADR_BATTERY = 10'h00B;
	localparam logic [9:0] ADR_PART = 10'h00F;
	localparam logic [9:0] ADR_CONFIG = 10'h020;
	localparam logic [9:0] ADR_SAG_THRESHOLD = 10'h024;
	localparam logic [9:0] ADR_MPU_REAL = 10'h025;
	localparam logic [9:0] ADR_MPU_REACT = 10'h026;
	localparam logic [9:0] ADR_GAIN_TRIM = 10'h027;
	localparam logic [9:0] ADR_STATUS = 10'h080;

	// ------------------------------------------------------------
	// Reset values and identity
	// ------------------------------------------------------------
	localparam logic [31:0] CONFIG_RST = 32'h0000_5020;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam logic [7:0] PART_CODE = 8'hA5; // Arbitrary value
	localparam logic [7:0] REVISION = 8'h01; // Arbitrary value

	// ------------------------------------------------------------
	// Config word field positions
	// ------------------------------------------------------------
	localparam int CFG_GAIN8_A = 0;
	localparam int CFG_GAIN8_B = 1;
	localparam int CFG_GAIN8_C = 2;
	localparam int CFG_PULSE_SRC = 3;
	localparam int CFG_TEMP_OWNER = 4;
	localparam int CFG_SAG_PULSE = 5;
	localparam int CFG_PHSEL0 = 6;
	localparam int CFG_PHSEL1 = 7;
	localparam int CFG_CNT_LO = 8;
	localparam int CFG_CNT_HI = 15;
	localparam int CFG_SAGEN_A = 16;
	localparam int CFG_PULSE_SLOW = 19;
	localparam int CFG_PULSE_FAST = 20;

	// ------------------------------------------------------------
	// Status word field positions
	// ------------------------------------------------------------
	localparam int ST_SAG_A = 25;
	localparam int ST_SQUARE_WAVE = 28;

	// Raw memory geometry
	localparam int RAW_AW = 4;
	localparam int RAW_DW = 32;
endpackage
`default_nettype wire

// *** rtl/mesc_raw_mem.sv ***
// Purpose: Small word store for filtered front-end results
// Assumes: One write port and one read port on the same clock
// Notes: Read data is registered, one cycle after the read address
`timescale 1ns/100ps
`default_nettype none
module mesc_raw_mem (
	input wire logic clk, // Clock
	input wire logic nrst, // Async reset, active low
	input wire logic wr_en, // Write strobe
	input wire logic [mesc_pkg::RAW_AW-1:0] wr_idx, // Write index
	input wire logic [mesc_pkg::RAW_DW-1:0] wr_data, // Write data
	input wire logic [mesc_pkg::RAW_AW-1:0] rd_idx, // Read index
	output logic [mesc_pkg::RAW_DW-1:0] rd_data // Registered read data
);
	logic [mesc_pkg::RAW_DW-1:0] mem_r [0:(1<<mesc_pkg::RAW_AW)-1];

	// ------------------------------------------------------------
	// Storage; words read zero until first frame lands
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < (1<<mesc_pkg::RAW_AW); i++) begin
				mem_r[i] <= mesc_pkg::WORD_RST;
			end
		end else if (wr_en) begin
			mem_r[wr_idx] <= wr_data;
		end
	end

	// Registered read port
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_data <= mesc_pkg::WORD_RST;
		end else begin
			rd_data <= mem_r[rd_idx];
		end
	end
endmodule
`default_nettype wire

// *** verification/mesc_top_sva.sv ***
// Purpose: Port checks for the status/config block
// Assumes: One clock, async active-low reset
// Notes: Keeps a shadow of the config word
`timescale 1ns/100ps
`default_nettype none
module mesc_top_sva (
	input wire logic clk, // Clock
	input wire logic nrst, // Reset
	input wire logic [11:0] mpu_addr, // Address
	input wire logic mpu_rd, // Read
	input wire logic mpu_wr, // Write
	input wire logic [31:0] mpu_wdata, // Wdata
	input wire logic [31:0] mpu_rdata, // Rdata
	input wire logic mpu_rvalid, // Valid
	input wire logic [31:0] real_energy_sum, // Energy
	input wire logic [31:0] real_pulse_rate, // Rate
	input wire logic [2:0] current_gain8, // Gain
	input wire logic [1:0] pll_phase, // Phase
	input wire logic [1:0] pulse_scale, // Scale
	input wire logic aux_pulse_output // Aux
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// ----------------
	// Config shadow
	// ----------------
	logic [31:0] cfg_r;
	logic cfg_hit;
	logic st_hit;
	assign cfg_hit = mpu_wr && mpu_addr[11:2] == mesc_pkg::ADR_CONFIG;
	assign st_hit = mpu_rd && mpu_addr[11:2] == mesc_pkg::ADR_STATUS;
	// Mode bits are needed to know when rate and aux may move
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_r <= mesc_pkg::CONFIG_RST;
		end else if (cfg_hit) begin
			cfg_r <= mpu_wdata;
		end
	end
	// Read answer timing
	read_latency_a: assert property (mpu_rd |-> ##2 mpu_rvalid)
		else $error("read answer late");
	valid_cause_a: assert property (mpu_rvalid |-> $past(mpu_rd, 2))
		else $error("answer without read");
	part_word_a: assert property ((mpu_rd && mpu_addr[11:2] == mesc_pkg::ADR_PART) |-> ##2
		mpu_rdata == {16'h0000, mesc_pkg::PART_CODE, mesc_pkg::REVISION})
		else $error("part word wrong");
	status_zero_a: assert property (st_hit |-> ##2 (mpu_rdata[31:29] == 3'h0
		&& mpu_rdata[24:0] == 25'h0)) else $error("unused status bits set");
	// Derived outputs two cycles after a config write
	gain_follow_a: assert property (cfg_hit |-> ##2
		current_gain8 == $past(mpu_wdata[2:0], 2)) else $error("gain select wrong");
	phase_follow_a: assert property (cfg_hit |-> ##2
		pll_phase == $past(mpu_wdata[7:6], 2)) else $error("phase select wrong");
	scale_follow_a: assert property (cfg_hit |-> ##2
		pulse_scale == $past(mpu_wdata[20:19], 2)) else $error("pulse scale wrong");
	rate_source_a: assert property ((!cfg_r[3]) [*2] |->
		real_pulse_rate == $past(real_energy_sum)) else $error("engine rate not used");
	// Aux stays put while sag signalling is off
	aux_quiet_a: assert property ((!cfg_r[5]) [*3] |-> $stable(aux_pulse_output))
		else $error("aux moved while off");
endmodule
bind mesc_top mesc_top_sva i_sva (.clk(clk), .nrst(nrst), .mpu_addr(mpu_addr), .mpu_rd(mpu_rd),
	.mpu_wr(mpu_wr), .mpu_wdata(mpu_wdata), .mpu_rdata(mpu_rdata), .mpu_rvalid(mpu_rvalid),
	.real_energy_sum(real_energy_sum), .real_pulse_rate(real_pulse_rate),
	.current_gain8(current_gain8), .pll_phase(pll_phase), .pulse_scale(pulse_scale),
	.aux_pulse_output(aux_pulse_output));
`default_nettype wire

// *** verification/mesc_mpu_model.sv ***
// Purpose: Processor side of the shared engine words
// Assumes: Strobes one cycle, driven at the falling edge
// Notes: Idle address and data show inverted values
`timescale 1ns/100ps
`default_nettype none
module mesc_mpu_model (
	input wire logic clk, // Clock
	output var logic [11:0] mpu_addr, // Address
	output var logic mpu_rd, // Read
	output var logic mpu_wr, // Write
	output var logic [31:0] mpu_wdata, // Wdata
	input wire logic [31:0] mpu_rdata, // Rdata
	input wire logic mpu_rvalid // Valid
);
	// ----------------
	// Bus cycles
	// ----------------
	initial begin
		mpu_addr = 12'h000;
		mpu_rd = 1'b0;
		mpu_wr = 1'b0;
		mpu_wdata = 32'h0;
	end
	// Whole-word write; stale values never linger on the bus
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(negedge clk);
		mpu_addr = a;
		mpu_wdata = d;
		mpu_wr = 1'b1;
		@(negedge clk);
		mpu_wr = 1'b0;
		mpu_addr = ~a;
		mpu_wdata = ~d;
	endtask
	// Read; a missing answer returns unknown so compares fail
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		int n;
		n = 0;
		@(negedge clk);
		mpu_addr = a;
		mpu_rd = 1'b1;
		@(negedge clk);
		mpu_rd = 1'b0;
		mpu_addr = ~a;
		while (mpu_rvalid !== 1'b1 && n < 4) begin
			@(negedge clk);
			n++;
		end
		d = (n < 4) ? mpu_rdata : 32'hX;
	endtask
endmodule
`default_nettype wire

// *** verification/mesc_top_tb_top.sv ***
// Purpose: Register and sag tests for the status/config block
// Assumes: Inputs driven at the falling edge
// Notes: Bus cycles come from the processor model
`timescale 1ns/100ps
`default_nettype none
module mesc_top_tb_top;
	logic clk, nrst, mpu_rd, mpu_wr, mpu_rvalid, frame_wr, sample_stb, pass_end, aux_pulse_output;
	logic [11:0] mpu_addr;
	logic [31:0] mpu_wdata, mpu_rdata, frame_data, volt_a, volt_b, volt_c, d;
	logic [31:0] real_energy_sum, reactive_energy_sum, engine_gain_trim;
	logic [31:0] real_pulse_rate, reactive_pulse_rate, reference_gain_trim;
	logic [3:0] frame_idx;
	logic [2:0] current_gain8;
	logic [1:0] pll_phase, pulse_scale;
	logic [3:0] raw_idx [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA, 4'hB};
	int mismatches = 0;
	int n_tests = 0;
	// ----------------
	// Instances
	// ----------------
	mesc_top i_dut (.clk(clk), .nrst(nrst), .mpu_addr(mpu_addr), .mpu_rd(mpu_rd),
		.mpu_wr(mpu_wr), .mpu_wdata(mpu_wdata), .mpu_rdata(mpu_rdata), .mpu_rvalid(mpu_rvalid),
		.frame_wr(frame_wr), .frame_idx(frame_idx), .frame_data(frame_data),
		.sample_stb(sample_stb), .volt_a(volt_a), .volt_b(volt_b), .volt_c(volt_c),
		.pass_end(pass_end), .real_energy_sum(real_energy_sum),
		.reactive_energy_sum(reactive_energy_sum), .engine_gain_trim(engine_gain_trim),
		.real_pulse_rate(real_pulse_rate), .reactive_pulse_rate(reactive_pulse_rate),
		.reference_gain_trim(reference_gain_trim), .current_gain8(current_gain8),
		.pll_phase(pll_phase), .pulse_scale(pulse_scale), .aux_pulse_output(aux_pulse_output));
	mesc_mpu_model i_mpu (.clk(clk), .mpu_addr(mpu_addr), .mpu_rd(mpu_rd), .mpu_wr(mpu_wr),
		.mpu_wdata(mpu_wdata), .mpu_rdata(mpu_rdata), .mpu_rvalid(mpu_rvalid));
	// Clock and watchdog; whole run is under two hundred cycles
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#(20000 * 100);
		mismatches++;
		close_out();
	end
	// ----------------
	// Helpers
	// ----------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// One sample strobe with all three phase voltages
	task automatic sample(input logic [31:0] va, input logic [31:0] vb, input logic [31:0] vc);
		@(negedge clk);
		volt_a = va;
		volt_b = vb;
		volt_c = vc;
		sample_stb = 1'b1;
		@(negedge clk);
		sample_stb = 1'b0;
	endtask
	task automatic pass();
		@(negedge clk);
		pass_end = 1'b1;
		@(negedge clk);
		pass_end = 1'b0;
		@(negedge clk);
	endtask
	// ----------------
	// Tests
	// ----------------
	initial begin
		{nrst, frame_wr, sample_stb, pass_end, frame_idx, frame_data} = '0;
		{volt_a, volt_b, volt_c} = '0;
		real_energy_sum = 32'h0000_1234;
		reactive_energy_sum = 32'h0000_5678;
		engine_gain_trim = 32'h0000_0777;
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		i_mpu.rd(12'h080, d);
		check(d, 32'h0000_5020);
		check({25'h0, current_gain8, pll_phase, pulse_scale}, 32'h0);
		$display("reset test done");
		// Raw words: front end writes land, processor writes do not
		foreach (raw_idx[i]) begin
			@(negedge clk);
			{frame_wr, frame_idx, frame_data} = {1'b1, raw_idx[i], 32'hC0DE_0000 + 32'(i)};
			@(negedge clk);
			frame_wr = 1'b0;
			i_mpu.wr({6'h00, raw_idx[i], 2'h0}, 32'hFFFF_FFFF);
			i_mpu.rd({6'h00, raw_idx[i], 2'h0}, d);
			check(d, 32'hC0DE_0000 + 32'(i));
		end
		i_mpu.rd(12'h02F, d);
		check(d, 32'hC0DE_0008);
		i_mpu.wr(12'h03C, 32'hFFFF_FFFF);
		i_mpu.rd(12'h03C, d);
		check(d, {16'h0000, mesc_pkg::PART_CODE, mesc_pkg::REVISION});
		i_mpu.rd(12'hFF8, d);
		check(d, 32'h0);
		$display("raw test done");
		// Config fields and pulse-rate source
		i_mpu.wr(12'h080, 32'h0018_00C5);
		i_mpu.rd(12'h080, d);
		check(d, 32'h0018_00C5);
		check({27'h0, current_gain8, pll_phase}, 32'h0000_0017);
		check({30'h0, pulse_scale}, 32'h3);
		check(real_pulse_rate, real_energy_sum);
		check(reactive_pulse_rate, reactive_energy_sum);
		i_mpu.wr(12'h094, 32'h0000_0ABC);
		i_mpu.wr(12'h098, 32'h0000_0DEF);
		i_mpu.wr(12'h080, 32'h0000_0008);
		repeat (2) @(negedge clk);
		check(real_pulse_rate, 32'h0000_0ABC);
		check(reactive_pulse_rate, 32'h0000_0DEF);
		pass();
		check(reference_gain_trim, engine_gain_trim);
		i_mpu.wr(12'h080, 32'h0000_0010);
		i_mpu.wr(12'h09C, 32'h0000_0ABD);
		pass();
		check(reference_gain_trim, 32'h0000_0ABD);
		$display("config test done");
		// Sag on phase A only, count two, signalling on aux
		i_mpu.wr(12'h090, 32'h0000_0064);
		i_mpu.wr(12'h080, 32'h0001_0220);
		sample(32'h0000_000A, 32'h0000_0005, 32'h0000_0005);
		sample(32'h0000_000A, 32'h0000_0005, 32'h0000_0005);
		repeat (2) @(negedge clk);
		// Aux left reset low; first sag flips it high
		check({31'h0, aux_pulse_output}, 32'h1);
		pass();
		i_mpu.rd(12'h200, d);
		check(d, 32'h1200_0000);
		sample(32'hFFFF_FF38, 32'h0000_0005, 32'h0000_0005);
		pass();
		i_mpu.rd(12'h200, d);
		check(d, 32'h0);
		i_mpu.wr(12'h080, 32'h0001_02A0);
		sample(32'hFFFF_FF38, 32'h0000_0005, 32'h0000_0032);
		pass();
		i_mpu.rd(12'h200, d);
		check(d, 32'h1000_0000);
		sample(32'h0000_000A, 32'h0000_0005, 32'h0000_0032);
		sample(32'h0000_000A, 32'h0000_0005, 32'h0000_0032);
		i_mpu.rd(12'h200, d);
		check(d, 32'h1000_0000);
		check({31'h0, aux_pulse_output}, 32'h0);
		pass();
		i_mpu.rd(12'h200, d);
		check(d, 32'h1200_0000);
		// Sag with signalling off leaves aux alone; phase B steers the wave
		i_mpu.wr(12'h080, 32'h0001_0240);
		sample(32'hFFFF_FF38, 32'hFFFF_FFFB, 32'h0000_0032);
		sample(32'h0000_000A, 32'hFFFF_FFFB, 32'h0000_0032);
		sample(32'h0000_000A, 32'hFFFF_FFFB, 32'h0000_0032);
		repeat (2) @(negedge clk);
		check({31'h0, aux_pulse_output}, 32'h0);
		pass();
		i_mpu.rd(12'h200, d);
		check(d, 32'h0200_0000);
		$display("sag test done");
		close_out();
	end
endmodule
`default_nettype wire
